/* cei_map.svh */
`ifndef CEI_MAP_SVH
`define CEI_MAP_SVH

// register byte offsets on the apb side
`define CEI_ADDR_W        8
`define CEI_OFF_CTRL      8'h00
`define CEI_OFF_STATUS    8'h04
`define CEI_OFF_MASK      8'h08
`define CEI_OFF_STATE     8'h0C
`define CEI_OFF_COUNT     8'h10

// control register fields
`define CEI_CTRL_W        8
`define CEI_CTRL_RISE_BIT 7
`define CEI_CTRL_FALL_BIT 6
`define CEI_SEL_W         3
`define CEI_PLUS_LSB      3
`define CEI_MINUS_LSB     0
`define CEI_CTRL_RST      8'h00

// status and mask fields
`define CEI_ST_W          3
`define CEI_ST_FLAG_BIT   0
`define CEI_ST_RISE_BIT   1
`define CEI_ST_FALL_BIT   2
`define CEI_ST_RST        3'h0
`define CEI_MASK_RST      3'h0

// event counters
`define CEI_CNT_W         8
`define CEI_CNT_MAX       8'hFF
`define CEI_CNT_RST       8'h00
`define CEI_FALL_CNT_LSB  8

// analog sources, one-hot route positions
`define CEI_NSRC          7
`define CEI_SRC_AGND      0
`define CEI_SRC_FVR       1
`define CEI_SRC_DAC       2
`define CEI_SRC_PIN1      3
`define CEI_SRC_PIN2      4
`define CEI_SRC_PIN3      5
`define CEI_SRC_PIN4      6
`define CEI_SRC_NONE      4'hF
`define CEI_ROUTE_RST     7'h00

// code-to-source maps, nibble i holds the source for select code i
`define CEI_PLUS_MAP      32'h012FFF43
`define CEI_MINUS_MAP     32'h0FF65433

`endif

/* cei_pkg.sv */
`include "cei_map.svh"

package cei_pkg;

  typedef struct packed {
    logic                    primed;
    logic                    level;
    logic                    rise;
    logic                    fall;
  } cei_edge_state_t;

  typedef struct packed {
    logic [`CEI_CTRL_W-1:0]  ctrl;
    logic [`CEI_ST_W-1:0]    status;
    logic [`CEI_ST_W-1:0]    mask;
    logic [`CEI_CNT_W-1:0]   rise_cnt;
    logic [`CEI_CNT_W-1:0]   fall_cnt;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
    logic                    irq;
    logic                    flag;
    logic [`CEI_NSRC-1:0]    plus_route;
    logic [`CEI_NSRC-1:0]    minus_route;
  } cei_state_t;

endpackage : cei_pkg

/* cei_edge_detect.sv */
`timescale 1ns/1ps

module cei_edge_detect
  import cei_pkg::*;
(
  input  wire logic pclk,     // system clock
  input  wire logic presetn,  // async reset, active low
  input  wire logic cen,      // clock enable
  input  wire logic level,    // sampled comparator result
  output logic      level_q,  // registered level
  output logic      rise,     // one-cycle pulse on low to high
  output logic      fall      // one-cycle pulse on high to low
);

  cei_edge_state_t st;
  cei_edge_state_t next_st;

  // the first sample after reset only primes, so a high result at start is no edge
  always_comb begin
    next_st        = st;
    next_st.primed = 1'b1;
    next_st.level  = level;
    next_st.rise   = st.primed & ~st.level & level;
    next_st.fall   = st.primed & st.level & ~level;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (cen) begin
      st <= next_st;
    end
  end

  assign level_q = st.level;
  assign rise    = st.rise;
  assign fall    = st.fall;

endmodule : cei_edge_detect

/* cei_sel_decode.sv */
`timescale 1ns/1ps
`include "cei_map.svh"

module cei_sel_decode
  import cei_pkg::*;
#(
  parameter int          NSRC = `CEI_NSRC,
  parameter logic [31:0] MAP  = `CEI_PLUS_MAP
)(
  input  wire logic [`CEI_SEL_W-1:0] code,   // select field
  output logic      [NSRC-1:0]       route   // one-hot source, zero when floating
);

  generate
    if (NSRC < 1 || NSRC > 15) begin : g_bad
      $error("cei_sel_decode: NSRC must be 1 to 15");
    end
  endgenerate

  logic [3:0] src;

  always_comb begin
    src   = MAP[4*code +: 4];
    route = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (src == 4'(i)) begin
        route[i] = 1'b1;
      end
    end
  end

endmodule : cei_sel_decode

/* cei_top.sv */
// Behaviour
// - falling-edge enable set: each high-to-low result transition sets the channel flag
// - falling-edge enable clear: high-to-low transitions leave the channel flag alone
// - plus select 111 analog ground, 110 reference buffer, 101 dac level
// - plus select codes 100, 011 and 010 leave the non-inverting node floating
// - control bits read and write, clear to zero on every reset
`timescale 1ns/1ps
`include "cei_map.svh"

module cei_top
  import cei_pkg::*;
(
  input  wire logic                   pclk,              // system clock
  input  wire logic                   presetn,           // async reset, active low
  input  wire logic                   cen,               // clock enable, freezes state
  input  wire logic                   psel,              // apb select
  input  wire logic                   penable,           // apb enable
  input  wire logic                   pwrite,            // apb direction
  input  wire logic [`CEI_ADDR_W-1:0] paddr,             // apb byte address
  input  wire logic [31:0]            pwdata,            // apb write data
  input  wire logic [3:0]             pstrb,             // apb byte strobes
  output logic      [31:0]            prdata,            // apb read data
  output logic                        pready,            // apb ready
  output logic                        pslverr,           // apb error, unmapped address
  input  wire logic                   comparator_result, // synchronised comparator output
  output logic                        channel_irq_flag,  // sticky channel flag
  output logic                        irq,               // masked interrupt level
  output logic      [`CEI_NSRC-1:0]   plus_route,        // noninverting_node source, one-hot
  output logic      [`CEI_NSRC-1:0]   minus_route        // inverting_node source, one-hot
);

  cei_state_t st;
  cei_state_t next_st;

  logic                    level_q;
  logic                    rise_evt;
  logic                    fall_evt;
  logic [`CEI_NSRC-1:0]    plus_dec;
  logic [`CEI_NSRC-1:0]    minus_dec;

  logic                    setup;
  logic                    access;
  logic                    wr;
  logic                    lane0;
  logic                    hit_ctrl;
  logic                    hit_status;
  logic                    hit_mask;
  logic                    hit_state;
  logic                    hit_count;
  logic                    mapped;
  logic [31:0]             rd_val;
  logic                    flag_set;
  logic [`CEI_ST_W-1:0]    st_set;
  logic [`CEI_ST_W-1:0]    st_clr;
  logic [`CEI_ST_W-1:0]    st_new;
  logic                    cnt_clr;

  cei_edge_detect u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .cen     (cen),
    .level   (comparator_result),
    .level_q (level_q),
    .rise    (rise_evt),
    .fall    (fall_evt)
  );

  cei_sel_decode #(
    .NSRC (`CEI_NSRC),
    .MAP  (`CEI_PLUS_MAP)
  ) u_plus_dec (
    .code  (st.ctrl[`CEI_PLUS_LSB +: `CEI_SEL_W]),
    .route (plus_dec)
  );

  cei_sel_decode #(
    .NSRC (`CEI_NSRC),
    .MAP  (`CEI_MINUS_MAP)
  ) u_minus_dec (
    .code  (st.ctrl[`CEI_MINUS_LSB +: `CEI_SEL_W]),
    .route (minus_dec)
  );

  // address decode, exact word match so unaligned addresses are unmapped
  always_comb begin
    hit_ctrl   = (paddr == `CEI_OFF_CTRL);
    hit_status = (paddr == `CEI_OFF_STATUS);
    hit_mask   = (paddr == `CEI_OFF_MASK);
    hit_state  = (paddr == `CEI_OFF_STATE);
    hit_count  = (paddr == `CEI_OFF_COUNT);
    mapped     = hit_ctrl | hit_status | hit_mask | hit_state | hit_count;
  end

  // apb phases; ready is raised in the first access cycle, so no wait states
  always_comb begin
    setup  = psel & ~penable;
    access = psel & penable & st.pready;
    wr     = access & pwrite & ~st.pslverr;
    lane0  = pstrb[0];
  end

  // read mux, upper bits read as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_val[`CEI_CTRL_W-1:0] = st.ctrl;
    end else if (hit_status) begin
      rd_val[`CEI_ST_W-1:0] = st.status;
    end else if (hit_mask) begin
      rd_val[`CEI_ST_W-1:0] = st.mask;
    end else if (hit_state) begin
      rd_val[0] = level_q;
    end else if (hit_count) begin
      rd_val[`CEI_CNT_W-1:0] = st.rise_cnt;
      rd_val[`CEI_FALL_CNT_LSB +: `CEI_CNT_W] = st.fall_cnt;
    end
  end

  // edge events into the sticky status bits
  always_comb begin
    flag_set = (rise_evt & st.ctrl[`CEI_CTRL_RISE_BIT])
             | (fall_evt & st.ctrl[`CEI_CTRL_FALL_BIT]);
    st_set = '0;
    st_set[`CEI_ST_FLAG_BIT] = flag_set;
    st_set[`CEI_ST_RISE_BIT] = rise_evt;
    st_set[`CEI_ST_FALL_BIT] = fall_evt;
    st_clr = '0;
    if (wr && hit_status && lane0) begin
      st_clr = pwdata[`CEI_ST_W-1:0];
    end
    // a set in the same cycle as its clear survives
    st_new  = (st.status & ~st_clr) | st_set;
    cnt_clr = wr & hit_count;
  end

  always_comb begin
    next_st = st;

    next_st.pready = setup;
    if (setup) begin
      next_st.pslverr = ~mapped;
      next_st.prdata  = (pwrite || !mapped) ? 32'h0000_0000 : rd_val;
    end else if (access) begin
      next_st.pslverr = 1'b0;
      next_st.prdata  = 32'h0000_0000;
    end

    if (wr && hit_ctrl && lane0) begin
      next_st.ctrl = pwdata[`CEI_CTRL_W-1:0];
    end
    if (wr && hit_mask && lane0) begin
      next_st.mask = pwdata[`CEI_ST_W-1:0];
    end

    next_st.status = st_new;
    next_st.flag   = st_new[`CEI_ST_FLAG_BIT];
    next_st.irq    = |(st_new & next_st.mask);

    // counters saturate; an event in the clearing cycle counts as one
    if (cnt_clr) begin
      next_st.rise_cnt = rise_evt ? `CEI_CNT_W'(1) : `CEI_CNT_RST;
      next_st.fall_cnt = fall_evt ? `CEI_CNT_W'(1) : `CEI_CNT_RST;
    end else begin
      if (rise_evt && st.rise_cnt != `CEI_CNT_MAX) begin
        next_st.rise_cnt = st.rise_cnt + `CEI_CNT_W'(1);
      end
      if (fall_evt && st.fall_cnt != `CEI_CNT_MAX) begin
        next_st.fall_cnt = st.fall_cnt + `CEI_CNT_W'(1);
      end
    end

    // routes lag a control write by one cycle; switches change break-before-make free
    next_st.plus_route  = plus_dec;
    next_st.minus_route = minus_dec;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st             <= '0;
      st.ctrl        <= `CEI_CTRL_RST;
      st.status      <= `CEI_ST_RST;
      st.mask        <= `CEI_MASK_RST;
      st.rise_cnt    <= `CEI_CNT_RST;
      st.fall_cnt    <= `CEI_CNT_RST;
      st.plus_route  <= `CEI_ROUTE_RST;
      st.minus_route <= `CEI_ROUTE_RST;
    end else if (cen) begin
      st <= next_st;
    end
  end

  assign prdata           = st.prdata;
  assign pready           = st.pready;
  assign pslverr          = st.pslverr;
  assign channel_irq_flag = st.flag;
  assign irq              = st.irq;
  assign plus_route       = st.plus_route;
  assign minus_route      = st.minus_route;

endmodule : cei_top

/* cei_top_assertions.sv */
`timescale 1ns/1ps

module cei_chk
  import cei_pkg::*;
(
  input wire logic       pclk,              // clock
  input wire logic       presetn,           // reset
  input wire logic       cen,               // enable
  input wire logic       psel,              // apb
  input wire logic       penable,           // apb
  input wire logic       pwrite,            // apb
  input wire logic [7:0] paddr,             // apb
  input wire logic [31:0] pwdata,           // apb
  input wire logic [3:0] pstrb,             // apb
  input wire logic       pready,            // apb
  input wire logic       pslverr,           // apb
  input wire logic       comparator_result, // level in
  input wire logic       channel_irq_flag,  // flag
  input wire logic       irq,               // interrupt
  input wire logic [6:0] plus_route,        // route
  input wire logic [6:0] minus_route        // route
);
  localparam logic [6:0] PM [8] = '{7'h08, 7'h10, 7'h00, 7'h00, 7'h00, 7'h04, 7'h02, 7'h01};
  localparam logic [6:0] MM [8] = '{7'h08, 7'h08, 7'h10, 7'h20, 7'h40, 7'h00, 7'h00, 7'h01};
  logic [7:0] ctl;
  logic [2:0] msk;
  logic       r1, ok, hr, hf, hit, wr;
  assign wr  = psel && penable && pready && pwrite && cen && pstrb[0];
  assign hr  = ok && cen && !r1 && comparator_result;
  assign hf  = ok && cen && r1 && !comparator_result;
  assign hit = (hr && ctl[7]) || (hf && ctl[6]);
  // shadows of ctrl and mask, since only the ports are visible
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= 8'h00;
      msk <= 3'h0;
      r1  <= 1'b0;
      ok  <= 1'b0;
    end else if (cen) begin
      r1 <= comparator_result;
      ok <= 1'b1;
      if (wr && paddr == 8'h00) ctl <= pwdata[7:0];
      if (wr && paddr == 8'h08) msk <= pwdata[2:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_fall_sets_flag: assert property (hf && ctl[6] |-> ##[2:4] channel_irq_flag)
    else $error("flag not set on enabled fall");
  a_rise_sets_flag: assert property (hr && ctl[7] |-> ##[2:4] channel_irq_flag)
    else $error("flag not set on enabled rise");
  a_no_stray_flag: assert property ($rose(channel_irq_flag) |->
    $past(hit, 2) || $past(hit, 3) || $past(hit, 4)) else $error("flag set without event");
  a_irq_masked: assert property (msk == 3'h0 && $past(msk) == 3'h0 |-> !irq)
    else $error("irq while masked");
  a_irq_follows_flag: assert property (msk[0] && $past(msk[0]) && channel_irq_flag |-> irq)
    else $error("irq missing");
  a_ready_next: assert property (psel && !penable && cen |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready && cen |=> !pready)
    else $error("pready held");
  a_err_map: assert property (psel && !penable && cen |=> pslverr ==
    !($past(paddr) inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10})) else $error("pslverr wrong");
  a_plus_route: assert property (ok && $stable(ctl) |-> plus_route == PM[ctl[5:3]])
    else $error("plus route wrong");
  a_minus_route: assert property (ok && $stable(ctl) |-> minus_route == MM[ctl[2:0]])
    else $error("minus route wrong");
  c_fall: cover property (hf && ctl[6]);
  c_rise: cover property (hr && ctl[7]);
  c_err: cover property (pslverr);
endmodule : cei_chk

bind cei_top cei_chk cei_chk_inst (.pclk, .presetn, .cen, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .pready, .pslverr, .comparator_result, .channel_irq_flag, .irq,
  .plus_route, .minus_route);

/* cei_top_tb_top.sv */
`timescale 1ns/1ps

module cei_top_tb_top
  import cei_pkg::*;
;
  localparam logic [6:0] PM [8] = '{7'h08, 7'h10, 7'h00, 7'h00, 7'h00, 7'h04, 7'h02, 7'h01};
  localparam logic [6:0] MM [8] = '{7'h08, 7'h08, 7'h10, 7'h20, 7'h40, 7'h00, 7'h00, 7'h01};
  logic        pclk = 1'b0, presetn = 1'b0, cen = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, comparator_result = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, channel_irq_flag, irq, er;
  logic [6:0]  plus_route, minus_route;
  int          fail_count = 0, n_checks = 0;

  cei_top cei_top_inst (.pclk, .presetn, .cen, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .comparator_result, .channel_irq_flag, .irq,
    .plus_route, .minus_route);

  initial begin
    forever #25 pclk = ~pclk;
  end

  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  // one transfer, then an idle cycle so no strobe is driven twice at one edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fail_count++;
      close_out();
    end else begin
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : xfer

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask : rdc

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("ctrl", 8'h00, 32'h0);
    xfer(1'b1, 8'h00, 32'hFFFFFFFF);
    rdc("ctrl", 8'h00, 32'hFF);
    xfer(1'b0, 8'h40, 32'h0);
    check("unmapped err", er, 32'h1);
    check("unmapped data", rd, 32'h0);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("ctrl", 8'h00, 32'h0);
    for (int c = 0; c < 8; c++) begin
      xfer(1'b1, 8'h00, {26'h0, c[2:0], c[2:0]});
      repeat (2) @(posedge pclk);
      check("plus route", plus_route, PM[c]);
      check("minus route", minus_route, MM[c]);
    end
    for (int m = 0; m < 4; m++) begin
      xfer(1'b1, 8'h00, {24'h0, m[1:0], 6'h0});
      xfer(1'b1, 8'h04, 32'h7);
      comparator_result <= 1'b1;
      repeat (5) @(posedge pclk);
      check("flag rise", channel_irq_flag, m[1]);
      xfer(1'b1, 8'h04, 32'h7);
      comparator_result <= 1'b0;
      repeat (5) @(posedge pclk);
      check("flag fall", channel_irq_flag, m[0]);
    end
    pstrb <= 4'h0;
    xfer(1'b1, 8'h00, 32'h0);
    pstrb <= 4'hF;
    rdc("ctrl kept", 8'h00, 32'hC0);
    check("irq masked", irq, 32'h0);
    xfer(1'b1, 8'h08, 32'h1);
    rdc("mask", 8'h08, 32'h1);
    check("irq", irq, 32'h1);
    xfer(1'b0, 8'h04, 32'h0);
    check("status flag", rd[0], 32'h1);
    xfer(1'b1, 8'h04, 32'h7);
    repeat (2) @(posedge pclk);
    check("irq cleared", irq, 32'h0);
    check("flag cleared", channel_irq_flag, 32'h0);
    // a low enable must hide the rise until it returns
    cen <= 1'b0;
    comparator_result <= 1'b1;
    repeat (3) @(posedge pclk);
    check("frozen flag", channel_irq_flag, 32'h0);
    cen <= 1'b1;
    repeat (3) @(posedge pclk);
    check("flag after freeze", channel_irq_flag, 32'h1);
    check("irq after freeze", irq, 32'h1);
    rdc("count", 8'h10, 32'h0000_0405);
    rdc("state", 8'h0C, 32'h1);
    close_out();
  end
endmodule : cei_top_tb_top
